/* File: src/cbuf_pkg.sv */
/*
 * Constants, states and the register image shared by the clock buffer control bank.
 * Assumes a single mclk domain and the two-wire serial bus pins sampled synchronously to mclk.
 */
`default_nettype none

package cbuf_pkg;

   // 7-bit bus address; the strap decode is outside this block
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h6C;

   // register indices
   localparam logic [7:0] IDX_PLL_READBACK = 8'h00;
   localparam logic [7:0] IDX_LOWER_EN = 8'h01;
   localparam logic [7:0] IDX_UPPER_EN = 8'h02;
   localparam logic [7:0] IDX_PLL_SW = 8'h03;
   localparam logic [7:0] IDX_MAP_A = 8'h04;
   localparam logic [7:0] IDX_MAKER_REV = 8'h05;
   localparam logic [7:0] IDX_PART_ID = 8'h06;
   localparam logic [7:0] IDX_READ_LEN = 8'h07;
   localparam logic [7:0] IDX_MAP_B = 8'h08;

   // reset values
   localparam logic [7:0] UPPER_EN_RST = 8'hFF;
   localparam logic PLL_SEL_RST = 1'b0;
   localparam logic [1:0] PLL_MODE_RST = 2'h3;
   localparam logic [7:0] MAP_A_RST = 8'hFF;
   localparam logic [7:0] MAP_B_RST = 8'h00;
   localparam logic [4:0] READ_LEN_RST = 5'h08;

   // field positions
   localparam int PLL_SEL_BIT = 3;
   localparam int PLL_MODE_HI = 2;
   localparam int PLL_MODE_LO = 1;
   localparam int READ_LEN_HI = 4;
   localparam int MAP_A_BASE = 5;

   // lower group enables live outside this bank, so they count as always on here but read back as 0
   localparam logic [7:0] LOWER_EN_FIXED = 8'hFF;

   // identification values: arbitrary, chosen for this design
   localparam logic [3:0] REV_NIBBLE = 4'hA;
   localparam logic [3:0] MAKER_NIBBLE = 4'h5;
   localparam logic [7:0] PART_ID = 8'h5A;

   // output driven by each pin of map b, bit 7 first
   localparam logic [7:0][3:0] MAP_B_TARGET = {4'hD, 4'hE, 4'hF, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4};

   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RECV = 5'h02,
      ST_ACK = 5'h04,
      ST_SEND = 5'h08,
      ST_HACK = 5'h10
   } bus_state_e;

   typedef enum logic [3:0] {
      PH_ADDR = 4'h1,
      PH_INDEX = 4'h2,
      PH_COUNT = 4'h4,
      PH_DATA = 4'h8
   } phase_e;

   typedef struct packed {
      logic [7:0] upper_en;
      logic pll_sel;
      logic [1:0] pll_mode;
      logic [7:0] map_a;
      logic [4:0] read_len;
      logic [7:0] map_b;
   } regs_s;

   localparam regs_s REGS_RST = '{UPPER_EN_RST, PLL_SEL_RST, PLL_MODE_RST, MAP_A_RST, READ_LEN_RST, MAP_B_RST};

endpackage : cbuf_pkg

`default_nettype wire

/* File: src/clock_buffer_smbus_control_bank.sv */
/*
 * Control register bank of a 16-output differential clock buffer, reached over the two-wire
 * serial bus as a block read/write slave, plus the output gating and PLL mode selection.
 * Assumes scl/sda and the gate pins are already synchronous to mclk; sda is open drain and the
 * surroundings resolve the wire from sda_oe.
 */
// What this block does
// - Byte 2 holds eight RW enables for outputs 15..8, default 1; 0 stops output.
// - An enabled output runs freely unless a mapped gate pin also gates it.
// - Byte 3 bit 3 picks PLL mode source: 0 strap latch, 1 software; reset 0.
// - With override on, PLL mode comes from byte 3 bits 2:1, RW, reset 1 each.
// - Software mode bits use the same code as the readback field.
// - Byte 0 bits 7:6 keep reporting the strap-latched mode even under override.
// - Byte 4 bit i maps gate pin i+5 onto output i+5; RW default 1.
// - A 0 in a map bit leaves that output free of that pin.
// - Byte 8 bits 7..0 map pins 12..5 onto outputs 13,14,15,0..4; default 0.
// - Byte 7 bits 4:0 are the RW read length; bits 7:5 read 0.
// - Read length resets to 8, so default block read gives bytes 0..7.
// - Block read: index write, repeated start, count byte then data until host nacks.
`timescale 1ns/1ns
`default_nettype none

module clock_buffer_smbus_control_bank #(
   parameter logic [6:0] SLAVE_ADDR = cbuf_pkg::DEV_ADDR_DEFAULT
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [7:0] gate_pins_n,
   input wire logic [1:0] pll_strap,
   output logic [15:0] output_run,
   output logic [1:0] pll_mode_out,
   output logic [1:0] pll_readback
);

   // byte engine position and the register image
   cbuf_pkg::bus_state_e state_reg;
   cbuf_pkg::phase_e phase_reg;
   cbuf_pkg::regs_s regs_reg;

   // pin history for edge detection
   logic scl_prev_reg;
   logic sda_prev_reg;

   // byte assembly, addressing and transfer bookkeeping
   logic [7:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] index_reg;
   logic [7:0] remain_reg;
   logic reading_reg;
   logic host_ack_reg;

   // open-drain drive, strap capture and flopped output controls
   logic sda_oe_reg;
   logic sda_out_reg;
   logic strap_taken_reg;
   logic [1:0] strap_reg;
   logic [15:0] output_run_reg;
   logic [1:0] pll_mode_reg;

   // decoded bus events, the read path and output gating
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic byte_done;
   logic wr_fire;
   logic [7:0] rd_byte;
   logic [15:0] pin_stop;
   logic [15:0] sw_enable;

   // bus conditions; start and stop are edges of sda while scl stays high
   // pins are taken as already synchronous; a glitch on them would read as a false start
   assign scl_rise = scl_in & ~scl_prev_reg;
   assign scl_fall = ~scl_in & scl_prev_reg;
   assign start_det = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
   assign stop_det = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;

   // the ninth clock never shifts, so a byte is done at the eighth bit's falling clock;
   // a data write lands then, and only while the announced count is not used up
   assign byte_done = scl_fall && (bit_cnt_reg == cbuf_pkg::BITS_PER_BYTE);
   assign wr_fire = (state_reg == cbuf_pkg::ST_RECV) && (phase_reg == cbuf_pkg::PH_DATA) && byte_done
                    && (remain_reg != 8'h00) && !start_det && !stop_det;

   // previous pin levels for edge detection
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_prev_reg <= scl_in;
         sda_prev_reg <= sda_in;
      end
   end

   // read mux; unmapped indices and reserved bits answer zero
   always_comb begin
      case (index_reg)
         cbuf_pkg::IDX_PLL_READBACK: rd_byte = {strap_reg, 6'h00};
         cbuf_pkg::IDX_LOWER_EN: rd_byte = 8'h00;
         cbuf_pkg::IDX_UPPER_EN: rd_byte = regs_reg.upper_en;
         cbuf_pkg::IDX_PLL_SW: rd_byte = {4'h0, regs_reg.pll_sel, regs_reg.pll_mode, 1'b0};
         cbuf_pkg::IDX_MAP_A: rd_byte = regs_reg.map_a;
         cbuf_pkg::IDX_MAKER_REV: rd_byte = {cbuf_pkg::REV_NIBBLE, cbuf_pkg::MAKER_NIBBLE};
         cbuf_pkg::IDX_PART_ID: rd_byte = cbuf_pkg::PART_ID;
         cbuf_pkg::IDX_READ_LEN: rd_byte = {3'h0, regs_reg.read_len};
         cbuf_pkg::IDX_MAP_B: rd_byte = regs_reg.map_b;
         default: rd_byte = 8'h00;
      endcase
   end

   // byte engine: receive, acknowledge, transmit and host acknowledge phases
   // flow: idle, recv, ack, then recv again or send for a read; send, hack, then send or idle
   // start and stop win over every state, since the host may issue them at any point
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= cbuf_pkg::ST_IDLE;
         phase_reg <= cbuf_pkg::PH_ADDR;
         shift_reg <= 8'h00;
         bit_cnt_reg <= 4'h0;
         index_reg <= 8'h00;
         remain_reg <= 8'h00;
         reading_reg <= 1'b0;
         host_ack_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else if (start_det) begin
         // a repeated start keeps the index so a read can follow the index write
         state_reg <= cbuf_pkg::ST_RECV;
         phase_reg <= cbuf_pkg::PH_ADDR;
         bit_cnt_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
      end else if (stop_det) begin
         state_reg <= cbuf_pkg::ST_IDLE;
         sda_oe_reg <= 1'b0;
      end else begin
         case (state_reg)
            cbuf_pkg::ST_IDLE: begin
               sda_oe_reg <= 1'b0;
            end
            cbuf_pkg::ST_RECV: begin
               if (scl_rise && bit_cnt_reg != cbuf_pkg::BITS_PER_BYTE) begin
                  shift_reg <= {shift_reg[6:0], sda_in};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (byte_done) begin
                  bit_cnt_reg <= 4'h0;
                  state_reg <= cbuf_pkg::ST_ACK;
                  sda_oe_reg <= 1'b1;
                  case (phase_reg)
                     cbuf_pkg::PH_ADDR: begin
                        reading_reg <= shift_reg[0];
                        if (shift_reg[7:1] != SLAVE_ADDR) begin
                           // not ours: stay off the bus until the next start
                           state_reg <= cbuf_pkg::ST_IDLE;
                           sda_oe_reg <= 1'b0;
                        end
                     end
                     cbuf_pkg::PH_INDEX: index_reg <= shift_reg;
                     cbuf_pkg::PH_COUNT: remain_reg <= shift_reg;
                     cbuf_pkg::PH_DATA: begin
                        if (remain_reg != 8'h00) begin
                           index_reg <= index_reg + 8'h01;
                           remain_reg <= remain_reg - 8'h01;
                        end else begin
                           // bytes beyond the announced count are refused
                           state_reg <= cbuf_pkg::ST_IDLE;
                           sda_oe_reg <= 1'b0;
                        end
                     end
                     default: state_reg <= cbuf_pkg::ST_IDLE;
                  endcase
               end
            end
            cbuf_pkg::ST_ACK: begin
               if (scl_fall) begin
                  bit_cnt_reg <= 4'h0;
                  if (phase_reg == cbuf_pkg::PH_ADDR && reading_reg) begin
                     // read opens with the length byte
                     shift_reg <= {3'h0, regs_reg.read_len};
                     sda_oe_reg <= 1'b1; // length msb is always 0
                     state_reg <= cbuf_pkg::ST_SEND;
                  end else begin
                     sda_oe_reg <= 1'b0;
                     state_reg <= cbuf_pkg::ST_RECV;
                     case (phase_reg)
                        cbuf_pkg::PH_ADDR: phase_reg <= cbuf_pkg::PH_INDEX;
                        cbuf_pkg::PH_INDEX: phase_reg <= cbuf_pkg::PH_COUNT;
                        default: phase_reg <= cbuf_pkg::PH_DATA;
                     endcase
                  end
               end
            end
            cbuf_pkg::ST_SEND: begin
               // next bit goes out just after scl falls, so sda is settled well before the rise
               if (scl_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (byte_done) begin
                  sda_oe_reg <= 1'b0;
                  state_reg <= cbuf_pkg::ST_HACK;
               end else if (scl_fall) begin
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  sda_oe_reg <= ~shift_reg[6];
               end
            end
            cbuf_pkg::ST_HACK: begin
               // host answer is taken at the rise and acted on at the fall
               if (scl_rise) begin
                  host_ack_reg <= ~sda_in;
               end else if (scl_fall) begin
                  bit_cnt_reg <= 4'h0;
                  if (host_ack_reg) begin
                     shift_reg <= rd_byte;
                     sda_oe_reg <= ~rd_byte[7];
                     index_reg <= index_reg + 8'h01;
                     state_reg <= cbuf_pkg::ST_SEND;
                  end else begin
                     // host nack ends the read; wait for stop
                     state_reg <= cbuf_pkg::ST_IDLE;
                     sda_oe_reg <= 1'b0;
                  end
               end
            end
            default: begin
               state_reg <= cbuf_pkg::ST_IDLE;
               sda_oe_reg <= 1'b0;
            end
         endcase
      end
   end

   // register writes; read-only and reserved bits never take host data
   // limitation: each byte lands on its own, so a multi-byte update is not atomic
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         regs_reg <= cbuf_pkg::REGS_RST;
      end else if (wr_fire) begin
         case (index_reg)
            cbuf_pkg::IDX_UPPER_EN: regs_reg.upper_en <= shift_reg;
            cbuf_pkg::IDX_PLL_SW: begin
               regs_reg.pll_sel <= shift_reg[cbuf_pkg::PLL_SEL_BIT];
               regs_reg.pll_mode <= shift_reg[cbuf_pkg::PLL_MODE_HI:cbuf_pkg::PLL_MODE_LO];
            end
            cbuf_pkg::IDX_MAP_A: regs_reg.map_a <= shift_reg;
            cbuf_pkg::IDX_READ_LEN: regs_reg.read_len <= shift_reg[cbuf_pkg::READ_LEN_HI:0];
            cbuf_pkg::IDX_MAP_B: regs_reg.map_b <= shift_reg;
            default: regs_reg <= regs_reg;
         endcase
      end
   end

   // strap is caught on the first edge after reset release, never under reset itself
   // the strap is read once, so a pin that moves later never reaches the readback
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         strap_taken_reg <= 1'b0;
         strap_reg <= 2'h0;
      end else if (!strap_taken_reg) begin
         strap_taken_reg <= 1'b1;
         strap_reg <= pll_strap;
      end
   end

   // one gate per pin and map; map a aims at outputs 5..12 and map b at the rest,
   // so every stop bit has exactly one driver
   // a mapped pin that is high (deasserted) stops its output; an unmapped pin has no say
   for (genvar g = 0; g < 8; g++) begin : gen_pin_gate
      // map a: pin g+5 onto output g+5
      assign pin_stop[g + cbuf_pkg::MAP_A_BASE] = regs_reg.map_a[g] & gate_pins_n[g];
      // map b: pin g+5 onto the output named by its target table
      assign pin_stop[cbuf_pkg::MAP_B_TARGET[g]] = regs_reg.map_b[g] & gate_pins_n[g];
   end

   // lower outputs keep a fixed software enable here; only their mapped pins can stop them
   assign sw_enable = {regs_reg.upper_en, cbuf_pkg::LOWER_EN_FIXED};

   // registered output controls; mode change is seen at once, the system warm reset makes it safe
   // trade-off: one cycle of latency buys glitch-free controls at the pins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         output_run_reg <= 16'h0000;
         pll_mode_reg <= cbuf_pkg::PLL_MODE_RST;
         sda_out_reg <= 1'b0;
      end else begin
         output_run_reg <= sw_enable & ~pin_stop;
         pll_mode_reg <= regs_reg.pll_sel ? regs_reg.pll_mode : strap_reg;
         sda_out_reg <= 1'b0; // open drain: only ever pulls low
      end
   end

   // every port comes straight from a flop
   assign sda_out = sda_out_reg;
   assign sda_oe = sda_oe_reg;
   assign output_run = output_run_reg;
   assign pll_mode_out = pll_mode_reg;
   assign pll_readback = strap_reg;

endmodule : clock_buffer_smbus_control_bank

`default_nettype wire

/* File: tb/cbuf_control_asserts.sv */
/* Concurrent checks on the control bank's ports, bound into every instance.
   Assumes one mclk domain with rst_n as its asynchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module cbuf_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [7:0] gate_pins_n,
   input wire logic [1:0] pll_strap,
   input wire logic [15:0] output_run,
   input wire logic [1:0] pll_mode_out,
   input wire logic [1:0] pll_readback
);
   logic [1:0] boot_cnt_reg;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // edges since reset release, saturating; defaults settle within the first two
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) boot_cnt_reg <= 2'h0;
      else if (boot_cnt_reg != 2'h3) boot_cnt_reg <= boot_cnt_reg + 2'h1;
   end
   AST_SDA_OPEN_DRAIN: assert property (sda_out == 1'b0)
      else $error("sda driven high");
   AST_OE_MOVES_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda enable moved while scl high");
   AST_OE_HELD_SCL_HIGH: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("sda enable unstable in scl high phase");
   AST_STRAP_CAPTURE: assert property (boot_cnt_reg == 2'h1 |-> pll_readback == $past(pll_strap))
      else $error("strap not captured after reset");
   AST_READBACK_HOLD: assert property (boot_cnt_reg == 2'h3 |-> $stable(pll_readback))
      else $error("strap readback moved");
   AST_MODE_FROM_STRAP: assert property (boot_cnt_reg == 2'h2 |-> pll_mode_out == pll_readback)
      else $error("mode not from strap after reset");
   AST_MODE_MOVES_SCL_LOW: assert property (boot_cnt_reg == 2'h3 && $changed(pll_mode_out) |-> !scl_in)
      else $error("mode changed outside a bus write");
   AST_RUN_DEFAULT: assert property (boot_cnt_reg == 2'h1 |->
      output_run == {3'h7, ~$past(gate_pins_n), 5'h1F})
      else $error("default output gating wrong");
   AST_PINS_LOW_RUN: assert property (boot_cnt_reg == 2'h3 && gate_pins_n == 8'h00 &&
      $past(gate_pins_n) == 8'h00 |-> output_run[7:0] == 8'hFF)
      else $error("lower output stopped with all pins asserted");
   // main scenarios reached
   COV_DEVICE_DRIVES: cover property (scl_in && sda_oe);
   COV_MODE_CHANGE: cover property (boot_cnt_reg == 2'h3 && $changed(pll_mode_out));
   COV_UPPER_STOP: cover property (output_run[15:8] != 8'hFF);
endmodule : cbuf_checker
bind clock_buffer_smbus_control_bank cbuf_checker chk (.mclk(mclk), .rst_n(rst_n), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .gate_pins_n(gate_pins_n), .pll_strap(pll_strap),
   .output_run(output_run), .pll_mode_out(pll_mode_out), .pll_readback(pll_readback));
`default_nettype wire

/* File: tb/clock_buffer_smbus_control_bank_tb.sv */
/* Self-checking bench for the clock buffer control bank.
   Assumes the host model drives the bus; the open-drain wire is resolved here. */
`timescale 1ns/1ns
`default_nettype none
module clock_buffer_smbus_control_bank_tb;
   localparam logic [7:0] WADDR = {cbuf_pkg::DEV_ADDR_DEFAULT, 1'b0};
   logic mclk, rst_n, scl, host_sda, sda_out, sda_oe, sel, ack;
   logic [7:0] gate_pins_n, up, ma, mb;
   logic [1:0] pll_strap, strap_q, pll_mode_out, pll_readback, mode;
   logic [15:0] output_run;
   logic [4:0] len;
   logic [7:0] q[$];
   int n_fail = 0;
   int n_tests = 0;
   int seed = 58;
   // open-drain wire with pull-up
   wire logic sda_wire = host_sda & ~sda_oe;
   clock_buffer_smbus_control_bank dut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .gate_pins_n(gate_pins_n), .pll_strap(pll_strap),
      .output_run(output_run), .pll_mode_out(pll_mode_out), .pll_readback(pll_readback));
   smbus_host_model host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_drv(host_sda));
   // 125 MHz
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   // expected read value of one index; unmapped places read zero
   function automatic logic [7:0] exp_byte(input logic [7:0] idx);
      case (idx)
         8'h00: return {strap_q, 6'h00};
         8'h02: return up;
         8'h03: return {4'h0, sel, mode, 1'b0};
         8'h04: return ma;
         8'h05: return {cbuf_pkg::REV_NIBBLE, cbuf_pkg::MAKER_NIBBLE};
         8'h06: return cbuf_pkg::PART_ID;
         8'h07: return {3'h0, len};
         8'h08: return mb;
         default: return 8'h00;
      endcase
   endfunction : exp_byte
   // expected gating: a mapped pin held high stops its output
   function automatic logic [15:0] exp_run(input logic [7:0] g);
      logic [15:0] r;
      r = {up, 8'hFF};
      for (int i = 0; i < 8; i++) begin
         if (ma[i] && g[i]) r[i + 5] = 1'b0;
         if (mb[i] && g[i]) r[i >= 5 ? 20 - i : 4 - i] = 1'b0;
      end
      return r;
   endfunction : exp_run
   // shadow of one accepted register write
   function automatic void apply(input logic [7:0] idx, input logic [7:0] d);
      case (idx)
         8'h02: up = d;
         8'h03: {sel, mode} = d[3:1];
         8'h04: ma = d;
         8'h07: len = d[4:0];
         8'h08: mb = d;
         default: ;
      endcase
   endfunction : apply
   // block write of q from index 0; bytes past the count and a foreign address are refused
   task automatic blk_wr(input logic [7:0] addr, input logic [7:0] cnt);
      logic [7:0] all[$];
      all = {addr, 8'h00, cnt, q};
      host.frame(1'b1, 1'b0);
      foreach (all[j]) begin
         host.wr_byte(all[j], ack);
         check(ack, addr == WADDR && j < cnt + 3);
         if (addr == WADDR && j >= 3 && j < cnt + 3) apply(8'(j - 3), all[j]);
      end
      host.frame(1'b0, 1'b1);
   endtask : blk_wr
   // block read: count byte, then n bytes from idx
   task automatic blk_rd(input logic [7:0] idx, input int n);
      logic [7:0] d;
      host.frame(1'b1, 1'b0);
      host.wr_byte(WADDR, ack);
      check(ack, 1'b1);
      host.wr_byte(idx, ack);
      check(ack, 1'b1);
      host.frame(1'b1, 1'b0);
      host.wr_byte(WADDR | 8'h01, ack);
      check(ack, 1'b1);
      host.rd_byte(1'b0, d);
      check(d, {3'h0, len});
      for (int k = 0; k < n; k++) begin
         host.rd_byte(k == n - 1, d);
         check(d, exp_byte(idx + 8'(k)));
      end
      host.frame(1'b0, 1'b1);
   endtask : blk_rd
   // gate pins, all-high corner first, then random
   task automatic check_outputs();
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         gate_pins_n <= (i == 0) ? 8'hFF : 8'($random(seed));
         repeat (3) @(posedge mclk);
         check(output_run, exp_run(gate_pins_n));
      end
      check(pll_mode_out, sel ? mode : strap_q);
      check(pll_readback, strap_q);
      check(sda_out, 1'b0);
   endtask : check_outputs
   // reset; the strap moves afterwards and must not reach the readback
   task automatic do_reset();
      rst_n <= 1'b0;
      pll_strap <= 2'($random(seed));
      {up, sel, mode, ma, len, mb} = {8'hFF, 1'b0, 2'h3, 8'hFF, 5'h08, 8'h00};
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      strap_q = pll_strap;
      repeat (4) @(posedge mclk);
      pll_strap <= ~pll_strap;
   endtask : do_reset
   // two passes, fast then slow host; the second reset is the warm reset after mode changes
   initial begin
      rst_n = 1'b0;
      gate_pins_n = 8'h00;
      pll_strap = 2'h0;
      for (int it = 0; it < 2; it++) begin
         do_reset();
         host.half = 2 + 3 * it;
         blk_rd(8'h00, 10);
         check_outputs();
         for (int w = 0; w < 3; w++) begin
            q = {};
            repeat (9) q.push_back(w == 0 ? 8'hFF : 8'($random(seed)));
            blk_wr(w == 2 ? WADDR ^ 8'h02 : WADDR, 8'(9 - w));
            blk_rd(8'(w + 2), 8);
            check_outputs();
         end
      end
      end_of_test();
   end
   // watchdog against a hung bus
   initial begin
      repeat (100000) @(posedge mclk);
      n_fail++;
      end_of_test();
   end
endmodule : clock_buffer_smbus_control_bank_tb
`default_nettype wire

/* File: tb/smbus_host_model.sv */
/* Two-wire bus host model: start, stop and byte tasks for the bench.
   Assumes the bench resolves the open-drain wire from sda_drv and the device enable. */
`timescale 1ns/1ns
`default_nettype none
module smbus_host_model (
   input wire logic mclk,
   input wire logic sda_wire,
   output logic scl,
   output logic sda_drv
);
   int half = 2;
   // bus idles released until the first start
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // one bit: sda moves one edge after scl falls so no false start or stop is seen
   task automatic bit_io(input logic b, output logic r);
      @(posedge mclk);
      sda_drv <= b;
      repeat (half) @(posedge mclk);
      scl <= 1'b1;
      repeat (half) @(posedge mclk);
      r = sda_wire;
      scl <= 1'b0;
   endtask : bit_io
   // start (a=1,b=0) or stop (a=0,b=1): sda moves while scl is high
   task automatic frame(input logic a, input logic b);
      @(posedge mclk);
      sda_drv <= a;
      repeat (half) @(posedge mclk);
      scl <= 1'b1;
      repeat (half) @(posedge mclk);
      sda_drv <= b;
      repeat (half) @(posedge mclk);
      scl <= b;
   endtask : frame
   // byte out, msb first, returns the device acknowledge
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask : wr_byte
   // byte in; the host acks every byte except the last
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask : rd_byte
endmodule : smbus_host_model
`default_nettype wire
